//--- pls_ctrl.v
// Decided for this implementation: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "pls_defs.vh"

// Function
// - Quick-power-down select resets to 1 and any reset sequence restores it.
// - Select 0: power-good fall resets configuration registers and starts startup.
// - After that reset, power-good rise relatches static selects and loads user config.
// - Select 1: fall triggers power-down load, next rise triggers power-up load.
// - Quick mode never starts startup nor relatches static selects.
// - Lock key write of 0xCB sets the write-protect flag.
// - Lock key write of 0x34 clears the flag; key register resets to zero.
// - Bit 7 drops group 1 output enable until next group 1 sync completes.
// - Bit 6 drops group 0 output enable until next group 0 sync completes.
// - Enable-clear bits self-clear; never written together with sync triggers.
// - Input divider hold bit low holds dividers set; resets to 1.
// - Bit 4 drives the global output enable directly; resets to 1.
// - Bit 3 starts group 1 sync of DPLL and dividers; self-clears.
// - Bit 2 starts group 0 sync of DPLL and dividers; self-clears.
// - Bit 1 starts sync of both groups at once; self-clears.
// - Affected outputs are squelched for about the squelch wait time.
// - Bit 0 restarts startup from oscillator calibration with divider sync; self-clears.
// - Sync drops enables, waits 1us doubling per code up to code 0xC, then stops and aligns.
// - Four-bit pin select picks power-good pin; 0xF disables the feature.
module pls_ctrl #(
  parameter SQ_UNIT_CYC = `PLS_CLK_MHZ * `PLS_SQ_BASE_US
) (
  // Clock and reset
  input  wire                   clk_sys,
  input  wire                   rst,
  // Avalon-MM slave
  input  wire [`PLS_ADDR_W-1:0] avs_address,
  input  wire                   avs_read,
  input  wire                   avs_write,
  input  wire [31:0]            avs_writedata,
  input  wire [3:0]             avs_byteenable,
  output reg  [31:0]            avs_readdata,
  output wire                   avs_waitrequest,
  // General-purpose pins
  input  wire [`PLS_NPINS-1:0]  gpio_in,
  // Startup sequencer requests
  output reg                    startup_start,
  output reg                    csel_latch,
  output reg                    user_cfg_load,
  output reg                    dyn_load_powerdown,
  output reg                    dyn_load_powerup,
  output reg                    startup_vco_restart,
  // Divider synchronisation
  output reg                    sync_align,
  output reg  [1:0]             sync_groups,
  output reg                    sync_busy,
  // Static controls
  output reg  [1:0]             group_oe,
  output reg                    global_oe,
  output reg                    input_divider_hold_n,
  output reg                    config_write_protect
);

  // Sync sequencer states
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_ALGN = 2'h2;

  // Power-good pin states
  localparam PS_RUN  = 1'h0;
  localparam PS_HOLD = 1'h1;

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, then the answer

  reg        ack_q;
  wire       req    = avs_read | avs_write;
  // A write acts only at the edge where the master sees waitrequest low
  wire       wr_ok  = avs_write & ack_q & avs_byteenable[0];
  wire [7:0] wdat   = avs_writedata[7:0];

  assign avs_waitrequest = req & ~ack_q;

  always @(posedge clk_sys) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  reg        quick_powerdown_select;
  reg  [7:0] lock_key_q;
  reg  [3:0] wait_code_q;
  reg  [3:0] pin_sel_q;
  reg        pin_rst_q;

  wire cfg_rst  = rst | pin_rst_q;
  wire wr_pwr   = wr_ok & (avs_address == `PLS_A_PWR) & ~config_write_protect;
  wire wr_lock  = wr_ok & (avs_address == `PLS_A_LOCK);
  wire wr_init  = wr_ok & (avs_address == `PLS_A_INIT) & ~config_write_protect;
  wire wr_cfg   = wr_ok & (avs_address == `PLS_A_CFG) & ~config_write_protect;

  // Power control: only the quick-power-down select is stored
  always @(posedge clk_sys) begin
    if (cfg_rst) begin
      quick_powerdown_select <= `PLS_PWR_RST;
    end else if (wr_pwr) begin
      quick_powerdown_select <= wdat[`PLS_PWR_QPD];
    end
  end

  // Lock key and write-protect flag; the key stays writable while protected
  always @(posedge clk_sys) begin
    if (cfg_rst) begin
      lock_key_q           <= `PLS_KEY_RST;
      config_write_protect <= 1'b0;
    end else if (wr_lock) begin
      lock_key_q <= wdat;
      if (wdat == `PLS_KEY_LOCK) begin
        config_write_protect <= 1'b1;
      end else if (wdat == `PLS_KEY_UNLOCK) begin
        config_write_protect <= 1'b0;
      end
    end
  end

  // Static bits of the init and sync register
  always @(posedge clk_sys) begin
    if (cfg_rst) begin
      input_divider_hold_n <= `PLS_HOLD_N_RST;
      global_oe            <= `PLS_GOE_RST;
    end else if (wr_init) begin
      input_divider_hold_n <= wdat[`PLS_IS_HOLD_N];
      global_oe            <= wdat[`PLS_IS_GOE];
    end
  end

  // Pin select and wait code come from common configuration; pin reset keeps them
  always @(posedge clk_sys) begin
    if (rst) begin
      wait_code_q <= `PLS_WAIT_RST;
      pin_sel_q   <= `PLS_PIN_RST;
    end else if (wr_cfg) begin
      wait_code_q <= wdat[`PLS_CFG_WAIT_HI:`PLS_CFG_WAIT_LO];
      pin_sel_q   <= wdat[`PLS_CFG_PIN_HI:`PLS_CFG_PIN_LO];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Self-clearing strobes from the init and sync register

  // Enable-clear bits never start a sync
  wire clr_g1   = wr_init & wdat[`PLS_IS_CLR1];
  wire clr_g0   = wr_init & wdat[`PLS_IS_CLR0];
  wire reinit   = wr_init & wdat[`PLS_IS_REINIT];
  wire trig_g1  = wr_init & (wdat[`PLS_IS_SYNC1] | wdat[`PLS_IS_SYNCALL] | wdat[`PLS_IS_REINIT]);
  wire trig_g0  = wr_init & (wdat[`PLS_IS_SYNC0] | wdat[`PLS_IS_SYNCALL] | wdat[`PLS_IS_REINIT]);

  // Restart request follows an accepted write by one cycle
  always @(posedge clk_sys) begin
    if (rst) begin
      startup_vco_restart <= 1'b0;
    end else begin
      startup_vco_restart <= reinit;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power-good pin: synchronise, select, detect edges

  reg  [`PLS_NPINS-1:0] pin_s1_q;
  reg  [`PLS_NPINS-1:0] pin_s2_q;
  reg                   pg_q;
  reg                   pg_prev_q;
  reg                   pg_en_q;
  reg                   ps_q;

  // Codes above the last pin, 0xF included, disable the feature
  wire pin_ok  = (pin_sel_q <= `PLS_PIN_LAST);
  wire pg_fall = pg_en_q & pg_prev_q & ~pg_q;
  wire pg_rise = pg_en_q & ~pg_prev_q & pg_q;

  // Synchroniser: only the second stage is read by the selector
  always @(posedge clk_sys) begin
    if (rst) begin
      pin_s1_q <= {`PLS_NPINS{1'b0}};
      pin_s2_q <= {`PLS_NPINS{1'b0}};
    end else begin
      pin_s1_q <= gpio_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Selected pin level
  wire pg_now = pin_ok ? pin_s2_q[pin_sel_q] : 1'b0;

  // Edge detector; until the pin is enabled the previous level follows it,
  // so enabling a pin that already stands high is not taken as an edge
  always @(posedge clk_sys) begin
    if (rst) begin
      pg_q      <= 1'b0;
      pg_prev_q <= 1'b0;
      pg_en_q   <= 1'b0;
    end else begin
      pg_q    <= pg_now;
      pg_en_q <= pin_ok;
      if (pg_en_q) begin
        pg_prev_q <= pg_q;
      end else begin
        pg_prev_q <= pg_now;
      end
    end
  end

  // Full reset on a fall with select 0, then wait for the rise; quick mode only loads

  always @(posedge clk_sys) begin
    if (rst) begin
      ps_q                <= PS_RUN;
      pin_rst_q           <= 1'b0;
      startup_start       <= 1'b0;
      csel_latch          <= 1'b0;
      user_cfg_load       <= 1'b0;
      dyn_load_powerdown  <= 1'b0;
      dyn_load_powerup    <= 1'b0;
    end else begin
      pin_rst_q           <= 1'b0;
      startup_start       <= 1'b0;
      csel_latch          <= 1'b0;
      user_cfg_load       <= 1'b0;
      dyn_load_powerdown  <= 1'b0;
      dyn_load_powerup    <= 1'b0;
      case (ps_q)
        PS_RUN: begin
          if (pg_fall) begin
            if (quick_powerdown_select) begin
              dyn_load_powerdown <= 1'b1;
            end else begin
              pin_rst_q     <= 1'b1;
              startup_start <= 1'b1;
              ps_q          <= PS_HOLD;
            end
          end else if (pg_rise && quick_powerdown_select) begin
            dyn_load_powerup <= 1'b1;
          end
        end
        PS_HOLD: begin
          if (pg_rise) begin
            csel_latch    <= 1'b1;
            user_cfg_load <= 1'b1;
            ps_q          <= PS_RUN;
          end
        end
        default: begin
          ps_q <= PS_RUN;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Divider synchronisation sequencer

  reg  [1:0]               st_q;
  reg  [1:0]               pend_q;
  reg  [`PLS_CNT_W-1:0]    cnt_q;
  wire [3:0]               code = (wait_code_q > `PLS_WAIT_MAX) ? `PLS_WAIT_MAX : wait_code_q;
  wire [`PLS_CNT_W-1:0]    unit = SQ_UNIT_CYC[`PLS_CNT_W-1:0];
  wire [`PLS_CNT_W-1:0]    wait_cyc = unit << code;
  wire [1:0]               done_g = (st_q == ST_ALGN) ? sync_groups : 2'b00;
  wire [`PLS_CNT_W-1:0]    one_cyc = {{(`PLS_CNT_W-1){1'b0}}, 1'b1};
  wire                     cnt_last = (cnt_q <= one_cyc);

  // Triggers arriving while busy are queued and run afterwards

  always @(posedge clk_sys) begin
    if (rst) begin
      st_q        <= ST_IDLE;
      pend_q      <= 2'b00;
      cnt_q       <= {`PLS_CNT_W{1'b0}};
      sync_groups <= 2'b00;
      sync_align  <= 1'b0;
      sync_busy   <= 1'b0;
    end else begin
      sync_align <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          pend_q <= 2'b00;
          if ((pend_q | {trig_g1, trig_g0}) != 2'b00) begin
            sync_groups <= pend_q | {trig_g1, trig_g0};
            cnt_q       <= wait_cyc;
            sync_busy   <= 1'b1;
            st_q        <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          pend_q <= pend_q | {trig_g1, trig_g0};
          if (cnt_last) begin
            sync_align <= 1'b1;
            st_q       <= ST_ALGN;
          end else begin
            cnt_q <= cnt_q - one_cyc;
          end
        end
        ST_ALGN: begin
          pend_q    <= pend_q | {trig_g1, trig_g0};
          sync_busy <= 1'b0;
          st_q      <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Group enables: dropped on clear or at sync start, restored when a sync completes;
  // completion wins over a same-cycle software clear
  wire [1:0] start_g = (st_q == ST_IDLE) ? (pend_q | {trig_g1, trig_g0}) : 2'b00;
  wire [1:0] clr_g   = {clr_g1, clr_g0};
  wire [1:0] drop_g  = clr_g | start_g;
  wire [1:0] oe_d    = (group_oe & ~drop_g) | done_g;

  always @(posedge clk_sys) begin
    if (rst) begin
      group_oe <= 2'b11;
    end else begin
      group_oe <= oe_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the wait cycle

  // Reserved and unmapped bits read as zero
  reg [7:0] rd_byte;

  always @* begin
    rd_byte = 8'h00;
    case (avs_address)
      `PLS_A_PWR: begin
        rd_byte = {7'h00, quick_powerdown_select};
      end
      `PLS_A_LOCK: begin
        rd_byte = lock_key_q;
      end
      `PLS_A_INIT: begin
        rd_byte = {2'b00, input_divider_hold_n, global_oe, 4'h0};
      end
      `PLS_A_STAT: begin
        rd_byte = {1'b0, ps_q, pg_q, sync_busy, config_write_protect, 1'b0, group_oe};
      end
      `PLS_A_CFG: begin
        rd_byte = {pin_sel_q, wait_code_q};
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // Captured in the wait cycle, so the data stand when waitrequest drops
  always @(posedge clk_sys) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

endmodule // pls_ctrl

`default_nettype wire

//--- pls_ctrl_assertions.sv
`timescale 1ns/1ns
`default_nettype none
`include "pls_defs.vh"
module pls_chk (
  // Clock, reset and bus
  input wire        clk_sys,
  input wire        rst,
  input wire [4:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire        avs_waitrequest,
  // Sequencer and controls
  input wire        startup_start,
  input wire        csel_latch,
  input wire        user_cfg_load,
  input wire        dyn_load_powerdown,
  input wire        dyn_load_powerup,
  input wire        startup_vco_restart,
  input wire        sync_align,
  input wire [1:0]  sync_groups,
  input wire        sync_busy,
  input wire [1:0]  group_oe,
  input wire        global_oe,
  input wire        input_divider_hold_n,
  input wire        config_write_protect
);
  wire wr_ok   = avs_write & ~avs_waitrequest & avs_byteenable[0];
  wire wr_key  = wr_ok & (avs_address == `PLS_A_LOCK);
  wire wr_init = wr_ok & (avs_address == `PLS_A_INIT) & ~config_write_protect;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  sequence s_one_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
  sequence s_drop; (group_oe & sync_groups) == 2'b00; endsequence
  sequence s_restore; ##1 ((group_oe & $past(sync_groups)) == $past(sync_groups)); endsequence
  wait_one_a: assert property (($rose(avs_read) || $rose(avs_write)) |-> s_one_wait)
    else $error("waitrequest not one cycle");
  lock_set_a: assert property (wr_key && avs_writedata[7:0] == `PLS_KEY_LOCK |=> config_write_protect)
    else $error("lock key did not protect");
  lock_clr_a: assert property (wr_key && avs_writedata[7:0] == `PLS_KEY_UNLOCK |=> !config_write_protect)
    else $error("unlock key did not release");
  goe_write_a: assert property (wr_init |=> global_oe == $past(avs_writedata[4]))
    else $error("global enable not written");
  hold_write_a: assert property (wr_init |=> input_divider_hold_n == $past(avs_writedata[5]))
    else $error("divider hold not written");
  reinit_start_a: assert property (wr_init && avs_writedata[0] |-> ##[0:2] startup_vco_restart)
    else $error("restart pulse missing");
  sync_start_a: assert property (wr_init && avs_writedata[3:1] != 3'h0 |-> ##[0:2] $rose(sync_busy))
    else $error("sync did not start");
  oe_drop_a: assert property ($rose(sync_busy) |-> s_drop)
    else $error("enables not dropped at sync");
  oe_restore_a: assert property (sync_align |-> s_restore)
    else $error("enables not restored");
  clr_only_a: assert property (wr_init && avs_writedata[7:6] != 2'b00 && avs_writedata[3:0] == 4'h0 |=> !sync_busy [*3])
    else $error("enable clear started sync");
  cfg_pair_a: assert property (csel_latch |-> user_cfg_load)
    else $error("select latch without load");
  quick_excl_a: assert property (dyn_load_powerdown || dyn_load_powerup |-> !startup_start && !csel_latch)
    else $error("quick mode ran startup");
endmodule // pls_chk
bind pls_ctrl pls_chk chk_u (.*);
`default_nettype wire

//--- pls_defs.vh
`ifndef PLS_DEFS_VH
`define PLS_DEFS_VH

// Register byte addresses
`define PLS_ADDR_W        5
`define PLS_A_PWR         5'h00
`define PLS_A_LOCK        5'h04
`define PLS_A_INIT        5'h08
`define PLS_A_STAT        5'h0C
`define PLS_A_CFG         5'h10

// Power control
`define PLS_PWR_QPD       0
`define PLS_PWR_RST       1'h1

// Lock key
`define PLS_KEY_RST       8'h00
`define PLS_KEY_LOCK      8'hCB
`define PLS_KEY_UNLOCK    8'h34

// Init and sync control bits
`define PLS_IS_CLR1       7
`define PLS_IS_CLR0       6
`define PLS_IS_HOLD_N     5
`define PLS_IS_GOE        4
`define PLS_IS_SYNC1      3
`define PLS_IS_SYNC0      2
`define PLS_IS_SYNCALL    1
`define PLS_IS_REINIT     0
`define PLS_HOLD_N_RST    1'h1
`define PLS_GOE_RST       1'h1

// Own configuration register fields
`define PLS_CFG_WAIT_LO   0
`define PLS_CFG_WAIT_HI   3
`define PLS_CFG_PIN_LO    4
`define PLS_CFG_PIN_HI    7
`define PLS_WAIT_RST      4'h2
`define PLS_WAIT_MAX      4'hC
`define PLS_PIN_RST       4'hF
`define PLS_PIN_NONE      4'hF
`define PLS_PIN_LAST      4'h8
`define PLS_NPINS         9

// Timing
`define PLS_CLK_MHZ       25
`define PLS_SQ_BASE_US    1
`define PLS_CNT_W         17

`endif

//--- pls_pg_model.sv
`timescale 1ns/1ns
`default_nettype none
module pls_pg_model (
  // Clock
  input  wire        clk_sys,
  // Pins towards the block
  output logic [8:0] gpio_in
);
  logic       pg_q = 1'b1;
  logic [7:0] noise_q = 8'h5A;
  // Unselected pins toggle so a stale level never looks quiet
  always @(posedge clk_sys) noise_q <= ~noise_q;
  assign gpio_in = {noise_q, pg_q};
  // Power-good holds long enough for each edge to be seen
  task automatic drive(input logic lv);
    @(posedge clk_sys);
    pg_q <= lv;
    repeat (10) @(posedge clk_sys);
  endtask
endmodule // pls_pg_model
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "pls_defs.vh"
module tb;
  localparam int SQ = 1;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  adr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h00000000;
  logic [3:0]  be = 4'hF;
  logic [31:0] rdat, rb;
  logic        wreq, st, cl, ul, pd, pu, vr, al, busy, gw, hn, wp;
  logic [1:0]  grp, goe;
  wire  [8:0]  gpio;
  wire  [5:0]  pv = {st, cl, ul, pd, pu, vr};
  int          pc[6], b[6];
  int          miscompares = 0;
  int          n_tests = 0;
  int          cyc = 0;
  always #20 clk_sys = ~clk_sys;
  pls_ctrl #(.SQ_UNIT_CYC(SQ)) dut_u (.clk_sys(clk_sys), .rst(rst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .gpio_in(gpio), .startup_start(st),
    .csel_latch(cl), .user_cfg_load(ul), .dyn_load_powerdown(pd), .dyn_load_powerup(pu),
    .startup_vco_restart(vr), .sync_align(al), .sync_groups(grp), .sync_busy(busy),
    .group_oe(goe), .global_oe(gw), .input_divider_hold_n(hn), .config_write_protect(wp));
  pls_pg_model pg_u (.clk_sys(clk_sys), .gpio_in(gpio));
  ////////////////////////////////////////
  task automatic close_out;
    if (miscompares == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    adr <= a;
    wdat <= {24'h000000, d};
    wr <= w;
    rd <= ~w;
    @(posedge clk_sys);
    while (wreq !== 1'b0) @(posedge clk_sys);
    rb = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wrr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rb, {24'h000000, e});
  endtask
  task automatic pchk(input int k, input int e);
    chk(32'(pc[k] - b[k]), 32'(e));
  endtask
  task automatic sync_run(input logic [7:0] d, input logic [1:0] g);
    int n;
    n = 0;
    b = pc;
    wrr(`PLS_A_INIT, d);
    while (busy !== 1'b1 && n < 10) begin
      @(posedge clk_sys);
      n++;
    end
    n = 0;
    chk(32'(grp), 32'(g));
    chk(32'(goe & g), 32'h0);
    while (al !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    chk(32'(n >= SQ * 4 - 2 && n <= SQ * 4 + 1), 32'h1);
    repeat (2) @(posedge clk_sys);
    chk(32'(goe), 32'h3);
    rdc(`PLS_A_INIT, 8'h30);
  endtask
  always @(posedge clk_sys) begin
    for (int i = 0; i < 6; i++) pc[i] <= pc[i] + pv[i];
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      miscompares++;
      close_out;
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rdc(`PLS_A_PWR, 8'h01);
    rdc(`PLS_A_LOCK, 8'h00);
    rdc(`PLS_A_INIT, 8'h30);
    rdc(5'h1C, 8'h00);
    rdc(`PLS_A_STAT, 8'h03);
    chk(32'({goe, gw, hn}), 32'hF);
    wrr(`PLS_A_CFG, 8'h02);
    wrr(`PLS_A_LOCK, `PLS_KEY_LOCK);
    chk(32'(wp), 32'h1);
    wrr(`PLS_A_INIT, 8'h00);
    rdc(`PLS_A_INIT, 8'h30);
    wrr(`PLS_A_LOCK, `PLS_KEY_UNLOCK);
    chk(32'(wp), 32'h0);
    be <= 4'hE;
    wrr(`PLS_A_INIT, 8'h00);
    be <= 4'hF;
    wrr(`PLS_A_INIT, 8'h10);
    chk(32'({gw, hn}), 32'h2);
    rdc(`PLS_A_INIT, 8'h10);
    wrr(`PLS_A_INIT, 8'h30);
    chk(32'({gw, hn}), 32'h3);
    sync_run(8'h38, 2'b10);
    sync_run(8'h34, 2'b01);
    sync_run(8'h32, 2'b11);
    sync_run(8'h31, 2'b11);
    pchk(0, 1);
    for (int i = 0; i < 2; i++) begin
      wrr(`PLS_A_INIT, 8'h30 | (8'h40 << i));
      repeat (5) @(posedge clk_sys);
      chk(32'(goe), 32'(2'b11 ^ (2'b01 << i)));
      rdc(`PLS_A_INIT, 8'h30);
      sync_run(8'h30 | (8'h04 << i), 2'b01 << i);
    end
    wrr(`PLS_A_PWR, 8'hFE);
    rdc(`PLS_A_PWR, 8'h00);
    wrr(`PLS_A_PWR, 8'h01);
    b = pc;
    pg_u.drive(1'b0);
    pchk(2, 1);
    pchk(5, 0);
    pg_u.drive(1'b1);
    pchk(1, 1);
    pchk(4, 0);
    wrr(`PLS_A_INIT, 8'h20);
    wrr(`PLS_A_PWR, 8'h00);
    wrr(`PLS_A_LOCK, `PLS_KEY_LOCK);
    b = pc;
    pg_u.drive(1'b0);
    pchk(5, 1);
    chk(32'({wp, gw, hn}), 32'h3);
    rdc(`PLS_A_PWR, 8'h01);
    rdc(`PLS_A_LOCK, 8'h00);
    pg_u.drive(1'b1);
    pchk(4, 1);
    pchk(3, 1);
    pchk(2, 0);
    wrr(`PLS_A_PWR, 8'h00);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rdc(`PLS_A_PWR, 8'h01);
    close_out;
  end
endmodule // tb
`default_nettype wire
